//--- logic/host_power_map.svh
// Offsets, field positions, reset values and timing counts of the host-domain bank
`ifndef HOST_POWER_MAP_SVH
`define HOST_POWER_MAP_SVH
// ****************************************
// Register offsets
// ****************************************
`define BRST_OFS        16'h4000
`define DOZE_OFS        16'h4004
`define PEND_OFS        16'h4008
`define FORCE_OFS       16'h400C
`define CFG_OFS         16'h4010
`define PINCR_OFS       16'h4014
// ****************************************
// Field positions and masks
// ****************************************
`define BRST_MAC_BIT    0
`define BRST_BB_BIT     1
`define BRST_HBUS_BIT   4
`define BRST_MASK       32'h0000_0013
`define BRST_RESET      32'h0000_0003
`define DOZE_SEL_LSB    16
`define DOZE_RELOAD_BIT 18
`define DOZE_WRPOL_BIT  19
`define DOZE_PEER_BIT   20
`define DOZE_STAT_BIT   21
`define DOZE_MASK       32'h003F_FFFF
`define DOZE_RESET      32'h0001_0000
`define FORCE_DOZE_BIT  0
`define FORCE_WAKE_BIT  1
`define CFG_CLKSRC_BIT  1
`define CFG_CLKSTOP_BIT 2
`define CFG_ASSOC_LSB   5
`define CFG_BEFIX_BIT   10
`define CFG_IRQDOZE_BIT 11
`define CFG_IRQWAKE_BIT 13
`define CFG_LEDHOLD_BIT 14
`define CFG_IDLEOFF_BIT 23
`define CFG_MASK        32'h00FE_6FE6
`define CFG_RESET       32'h0000_0000
`define PIN_SEL_LSB     12
`define PIN_EN_BIT      15
`define PIN_POL_BIT     16
`define PINCR_MASK      32'h0001_FFFF
`define PINCR_RESET     32'h0000_0000
// ****************************************
// Timing
// ****************************************
`define CLK_PERIOD_NS   50
`define HBUS_HOLD_CYC   64
`define DOZE_UNIT_NS    128000
`define DOZE_UNIT_CYC   (`DOZE_UNIT_NS / `CLK_PERIOD_NS)
`define LED_HOLD_NS     20000000
`define LED_HOLD_CYC    (`LED_HOLD_NS / `CLK_PERIOD_NS)
`define PERF_PRESCALE   256
`endif

//--- logic/host_power_pkg.sv
// Types shared by the host-domain power and pin control bank
package host_power_pkg;
  typedef enum logic [1:0] {
    SEL_WAKE = 2'b00,
    SEL_DOZE = 2'b01,
    SEL_AUTO = 2'b10,
    SEL_RSVD = 2'b11
  } doze_sel_t;
  typedef enum logic {
    ST_AWAKE = 1'b0,
    ST_DOZE  = 1'b1
  } doze_state_t;
  typedef enum logic [1:0] {
    PIN_NEVER  = 2'b00,
    PIN_LOW    = 2'b01,
    PIN_HIGH   = 2'b10,
    PIN_ALWAYS = 2'b11
  } pin_mode_t;
endpackage

//--- logic/sync3.sv
// Three-stage synchroniser whose output moves only when stages two and three agree
module sync3 #(
  parameter int W = 1
)(
  input  wire logic         clk_sys_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  // ****************************************
  // Capture chain and agreement filter
  // ****************************************
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      s1     <= '0;
      s2     <= '0;
      s3     <= '0;
      sync_o <= '0;
    end else begin
      s1     <= async_i;
      s2     <= s1;
      s3     <= s2;
      sync_o <= (s2 & ~(s2 ^ s3)) | (sync_o & (s2 ^ s3));
    end
  end
endmodule

//--- logic/doze_timer.sv
// Doze duration counter in 128 us units with load and restart policies
`include "host_power_map.svh"
module doze_timer (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  input  wire logic        len_wr_i,
  input  wire logic [15:0] len_i,
  input  wire logic        write_policy_i,
  input  wire logic        restart_policy_i,
  input  wire logic        beacon_target_time_i,
  input  wire logic        awake_i,
  output logic             busy_o
);
  localparam int UNIT = `DOZE_UNIT_CYC;
  localparam int PW   = $clog2(UNIT);
  logic [PW-1:0] pre;
  logic [15:0]   count;
  wire           unit_end = (pre == PW'(UNIT - 1)); // R3
  wire           restart  = beacon_target_time_i && awake_i &&
                            (!restart_policy_i || count == 16'h0); // R5
  // ****************************************
  // Counter: write wins over restart, then count down
  // ****************************************
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      pre   <= '0;
      count <= 16'h0;
    end else if (len_wr_i) begin
      pre   <= '0;
      count <= write_policy_i ? 16'h0 : len_i; // R6
    end else if (restart) begin
      pre   <= '0;
      count <= len_i;
    end else if (count != 16'h0) begin
      pre   <= unit_end ? '0 : PW'(pre + 1'b1);
      count <= unit_end ? 16'(count - 1'b1) : count;
    end
  end
  assign busy_o = (count != 16'h0);
endmodule

//--- logic/host_domain_power_gpio_regs.sv
// Host-domain reset, doze, configuration and pin control register bank
// ****************************************
// Overview of operation
// R1: Reset bit 1 holds baseband; bit 4 holds host bus, self-clears after 64 clocks.
// R2: Reset bit 0 holds the MAC core in warm reset.
// R3: Doze length gives sleep time in 128 us units.
// R4: Doze select: 00 wake, 01 doze, 10 automatic; 11 never written.
// R5: Beacon time restarts counter when awake; policy 1 only once expired.
// R6: Doze length write loads counter, or clears it when policy bit set.
// R7: Bit 20 picks infrastructure or peer network doze policy.
// R8: Counter top bit setting raises statistics interrupt only when enabled.
// R9: Pending bit mirrors the active-low host interrupt output.
// R10: Force register: bit 0 dozes now, bit 1 wakes now, reads zero.
// R11: Clock source and clock-stop permit reset low, then load from memory.
// R12: Software writes association state into bits 6 to 5.
// R13: Bit 10 clear keeps byte-enable fix active.
// R14: Bit 11 clear blocks host interrupt while dozing or about to.
// R15: Bit 13 clear keeps chip awake while interrupt pending.
// R16: Bit 14 clear holds doze indication 20 ms after wake.
// R17: Status bit 16 reads one while dozing.
// R18: Bit 23 turns idle associated indicator off instead of slow blink.
// R19: Bits 25 to 24 report low clock rate.
// R20: Each pin has two-bit drive mode: never, low, high, always.
// R21: Bits 14 to 12 choose the pin interrupt source.
// R22: Enabled pin interrupt follows selected input at chosen level.
// R23: Warm reset clears pin control when host bus hold is set.
// ****************************************
`include "host_power_map.svh"
module host_domain_power_gpio_regs #(
  parameter int PIN_COUNT    = 6,
  parameter int LED_HOLD_CYC = `LED_HOLD_CYC
)(
  input  wire logic                  clk_sys_i,
  input  wire logic                  rst_n_i,
  input  wire logic                  warm_rst_i,
  input  wire logic [15:0]           reg_addr_i,
  input  wire logic                  reg_wr_i,
  input  wire logic                  reg_rd_i,
  input  wire logic [31:0]           reg_wdata_i,
  output logic      [31:0]           reg_rdata_o,
  input  wire logic                  beacon_target_time_i,
  input  wire logic                  irq_req_i,
  input  wire logic                  sleep_clk_i,
  input  wire logic                  cfg_load_i,
  input  wire logic                  cfg_clk_src_i,
  input  wire logic                  cfg_clk_stop_i,
  input  wire logic [1:0]            low_clock_rate_i,
  input  wire logic [PIN_COUNT-1:0]  pin_out_value_i,
  input  wire logic [PIN_COUNT-1:0]  pin_in_i,
  output logic                       mac_core_hold_o,
  output logic                       baseband_hold_o,
  output logic                       host_bus_hold_o,
  output logic                       asleep_o,
  output host_power_pkg::doze_sel_t  doze_sel_o,
  output logic                       peer_network_doze_policy_o,
  output logic                       host_irq_n_o,
  output logic                       stat_irq_o,
  output logic                       low_clock_source_o,
  output logic                       clock_stop_permit_o,
  output logic      [1:0]            assoc_state_o,
  output logic                       byte_enable_fix_en_o,
  output logic                       indicator_doze_o,
  output logic                       idle_indicator_off_o,
  output logic      [PIN_COUNT-1:0]  pin_o,
  output logic      [PIN_COUNT-1:0]  pin_oe_o,
  output logic                       pin_irq_o
);
  import host_power_pkg::*;

  localparam int LW = $clog2(LED_HOLD_CYC + 1);

  // Parameter checks
  if (PIN_COUNT < 1 || PIN_COUNT > 6) begin : g_bad_pins
    $error("PIN_COUNT must lie between 1 and 6");
  end
  if (LED_HOLD_CYC < 1) begin : g_bad_hold
    $error("LED_HOLD_CYC must be at least 1");
  end

  // ****************************************
  // Decoding
  // ****************************************
  function automatic logic drive_en(input logic [1:0] mode, input logic dout);
    logic en;
    en = 1'b0;
    unique case (pin_mode_t'(mode))
      PIN_NEVER:  en = 1'b0;
      PIN_LOW:    en = !dout;
      PIN_HIGH:   en = dout;
      PIN_ALWAYS: en = 1'b1;
    endcase
    return en;
  endfunction

  logic [31:0]        block_reset_control;
  logic [31:0]        doze_control;
  logic [31:0]        cfg;
  logic [31:0]        pincr;
  logic [5:0]         hold_cnt;
  logic               force_doze;
  logic               force_wake;
  logic               host_irq_n;
  doze_state_t        state;
  doze_state_t        next_state;
  logic [LW-1:0]      led_cnt;
  logic [LW-1:0]      next_led_cnt;
  logic [PIN_COUNT-1:0] pin_sync;
  logic               sclk_sync;
  logic               sclk_prev;
  logic [7:0]         perf_pre;
  logic [23:0]        perf_cnt [2];
  logic [1:0]         msb_rise;
  logic [PIN_COUNT-1:0] drive;
  logic               doze_busy;

  // Address decode
  wire sel_reset_ctl = (reg_addr_i == `BRST_OFS);
  wire sel_doze_ctl  = (reg_addr_i == `DOZE_OFS);
  wire sel_pend      = (reg_addr_i == `PEND_OFS);
  wire sel_force     = (reg_addr_i == `FORCE_OFS);
  wire sel_cfg       = (reg_addr_i == `CFG_OFS);
  wire sel_pin       = (reg_addr_i == `PINCR_OFS);
  wire wr_reset_ctl  = reg_wr_i && sel_reset_ctl;
  wire wr_doze_ctl   = reg_wr_i && sel_doze_ctl;
  wire wr_force      = reg_wr_i && sel_force;
  wire wr_cfg        = reg_wr_i && sel_cfg;
  wire wr_pin        = reg_wr_i && sel_pin;

  // ****************************************
  // Reset control
  // ****************************************
  // Bit 4 is only set by a write; it clears itself after the hold
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      block_reset_control <= `BRST_RESET;
      hold_cnt            <= 6'h0;
    end else if (wr_reset_ctl) begin
      block_reset_control <= reg_wdata_i & `BRST_MASK; // R1 R2
      hold_cnt            <= 6'h0;
    end else if (block_reset_control[`BRST_HBUS_BIT]) begin
      hold_cnt <= 6'(hold_cnt + 1'b1);
      if (hold_cnt == 6'(`HBUS_HOLD_CYC - 1)) begin
        block_reset_control[`BRST_HBUS_BIT] <= 1'b0; // R1
      end
    end
  end

  assign mac_core_hold_o = block_reset_control[`BRST_MAC_BIT];  // R2
  assign baseband_hold_o = block_reset_control[`BRST_BB_BIT];   // R1
  assign host_bus_hold_o = block_reset_control[`BRST_HBUS_BIT]; // R1

  // ****************************************
  // Doze control and force commands
  // ****************************************
  // Doze control is untouched by warm reset
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      doze_control <= `DOZE_RESET;
    end else if (wr_doze_ctl) begin
      doze_control <= reg_wdata_i & `DOZE_MASK; // R3 R4
    end
  end

  // Force flags stay until the opposite command or a select write
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      force_doze <= 1'b0;
      force_wake <= 1'b0;
    end else if (wr_force) begin
      force_doze <= reg_wdata_i[`FORCE_DOZE_BIT] ||
                    (force_doze && !reg_wdata_i[`FORCE_WAKE_BIT]); // R10
      force_wake <= reg_wdata_i[`FORCE_WAKE_BIT] ||
                    (force_wake && !reg_wdata_i[`FORCE_DOZE_BIT]); // R10
    end else if (wr_doze_ctl) begin
      force_doze <= 1'b0;
      force_wake <= 1'b0;
    end
  end

  assign doze_sel_o                 = doze_sel_t'(doze_control[`DOZE_SEL_LSB +: 2]);
  assign peer_network_doze_policy_o = doze_control[`DOZE_PEER_BIT]; // R7

  // A write loads the length being written; a restart reloads the stored one
  wire [15:0] doze_len = wr_doze_ctl ? reg_wdata_i[15:0] : doze_control[15:0]; // R6

  doze_timer u_doze_timer (
    .clk_sys_i            (clk_sys_i),
    .rst_n_i              (rst_n_i),
    .len_wr_i             (wr_doze_ctl),
    .len_i                (doze_len),
    .write_policy_i       (reg_wdata_i[`DOZE_WRPOL_BIT]),
    .restart_policy_i     (doze_control[`DOZE_RELOAD_BIT]),
    .beacon_target_time_i (beacon_target_time_i),
    .awake_i              (state == ST_AWAKE),
    .busy_o               (doze_busy)
  );

  // Doze wish: force wake, then pending interrupt, then force doze, then select
  wire irq_keep  = irq_req_i && !cfg[`CFG_IRQWAKE_BIT]; // R15
  wire sel_doze  = (doze_sel_o == SEL_DOZE) ||
                   (doze_sel_o == SEL_AUTO && doze_busy); // R4
  wire want_doze = !force_wake && !irq_keep && (force_doze || sel_doze); // R10 R15

  // State transition
  always_comb begin
    next_state = state;
    unique case (state)
      ST_AWAKE: next_state = want_doze ? ST_DOZE : ST_AWAKE;
      ST_DOZE:  next_state = want_doze ? ST_DOZE : ST_AWAKE;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      state <= ST_DOZE;
    end else begin
      state <= next_state;
    end
  end

  assign asleep_o = (state == ST_DOZE);

  // ****************************************
  // Host interrupt gating
  // ****************************************
  wire irq_quiet = (asleep_o || want_doze) && !cfg[`CFG_IRQDOZE_BIT]; // R14

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      host_irq_n <= 1'b1;
    end else begin
      host_irq_n <= !(irq_req_i && !irq_quiet); // R14
    end
  end

  assign host_irq_n_o = host_irq_n;

  // ****************************************
  // Configuration and status
  // ****************************************
  // Memory load wins over a software write in the same cycle
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      cfg <= `CFG_RESET;
    end else if (cfg_load_i) begin
      cfg[`CFG_CLKSRC_BIT]  <= cfg_clk_src_i;  // R11
      cfg[`CFG_CLKSTOP_BIT] <= cfg_clk_stop_i; // R11
    end else if (wr_cfg) begin
      cfg <= reg_wdata_i & `CFG_MASK; // R12
    end
  end

  assign low_clock_source_o   = cfg[`CFG_CLKSRC_BIT];
  assign clock_stop_permit_o  = cfg[`CFG_CLKSTOP_BIT];   // R11
  assign assoc_state_o        = cfg[`CFG_ASSOC_LSB +: 2]; // R12
  assign byte_enable_fix_en_o = !cfg[`CFG_BEFIX_BIT];    // R13
  assign idle_indicator_off_o = cfg[`CFG_IDLEOFF_BIT];   // R18

  // Indicator hold after wake
  wire leaving = asleep_o && (next_state == ST_AWAKE);
  always_comb begin
    next_led_cnt = led_cnt;
    if (leaving && !cfg[`CFG_LEDHOLD_BIT]) begin
      next_led_cnt = LW'(LED_HOLD_CYC); // R16
    end else if (led_cnt != '0) begin
      next_led_cnt = LW'(led_cnt - 1'b1);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      led_cnt          <= '0;
      indicator_doze_o <= 1'b1;
    end else begin
      led_cnt          <= next_led_cnt;
      indicator_doze_o <= (next_state == ST_DOZE) || (next_led_cnt != '0); // R16
    end
  end

  // ****************************************
  // Doze performance counters on the low clock
  // ****************************************
  sync3 #(.W(1)) u_sclk_sync (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .async_i   (sleep_clk_i),
    .sync_o    (sclk_sync)
  );

  wire sclk_edge = sclk_sync && !sclk_prev;
  wire unit_tick = sclk_edge && (perf_pre == 8'(`PERF_PRESCALE - 1));

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      sclk_prev <= 1'b0;
      perf_pre  <= 8'h0;
    end else begin
      sclk_prev <= sclk_sync;
      perf_pre  <= sclk_edge ? 8'(perf_pre + 1'b1) : perf_pre;
    end
  end

  // Counter 0 counts awake time, counter 1 doze time
  for (genvar k = 0; k < 2; k++) begin : g_perf
    wire hit = unit_tick && (state == doze_state_t'(k));
    assign msb_rise[k] = hit && (perf_cnt[k] == 24'h7F_FFFF);
    always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
        perf_cnt[k] <= 24'h0;
      end else if (hit) begin
        perf_cnt[k] <= 24'(perf_cnt[k] + 1'b1);
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      stat_irq_o <= 1'b0;
    end else begin
      stat_irq_o <= doze_control[`DOZE_STAT_BIT] && (|msb_rise); // R8
    end
  end

  // ****************************************
  // Pin drive and pin interrupt
  // ****************************************
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      pincr <= `PINCR_RESET;
    end else if (warm_rst_i && block_reset_control[`BRST_HBUS_BIT]) begin
      pincr <= `PINCR_RESET; // R23
    end else if (wr_pin) begin
      pincr <= reg_wdata_i & `PINCR_MASK;
    end
  end

  for (genvar i = 0; i < PIN_COUNT; i++) begin : g_pin
    assign drive[i] = drive_en(pincr[2*i +: 2], pin_out_value_i[i]); // R20
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      pin_o    <= '0;
      pin_oe_o <= '0;
    end else begin
      pin_o    <= pin_out_value_i;
      pin_oe_o <= drive; // R20
    end
  end

  sync3 #(.W(PIN_COUNT)) u_pin_sync (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .async_i   (pin_in_i),
    .sync_o    (pin_sync)
  );

  wire [2:0] irq_src   = pincr[`PIN_SEL_LSB +: 3];
  wire       src_ok    = (32'(irq_src) < PIN_COUNT);
  wire       src_level = src_ok ? pin_sync[irq_src] : 1'b0; // R21

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      pin_irq_o <= 1'b0;
    end else begin
      pin_irq_o <= pincr[`PIN_EN_BIT] && src_ok &&
                   (src_level == pincr[`PIN_POL_BIT]); // R22
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  wire [31:0] cfg_view = {6'h0, low_clock_rate_i, cfg[23:17], asleep_o,
                          cfg[15:0]}; // R17 R19
  wire [31:0] rd_mux = sel_reset_ctl ? block_reset_control :
                       sel_doze_ctl  ? doze_control :
                       sel_pend      ? {31'h0, !host_irq_n} : // R9
                       sel_cfg       ? cfg_view :
                       sel_pin       ? pincr : 32'h0; // R10

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 32'h0;
    end else begin
      reg_rdata_o <= reg_rd_i ? rd_mux : 32'h0;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  sequence force_doze_seq;
    wr_force && reg_wdata_i[0] && !reg_wdata_i[1] ##1 !irq_keep;
  endsequence
  sequence force_wake_seq;
    wr_force && reg_wdata_i[1] ##1 1'b1;
  endsequence

  hbus_hold_len_a: assert property ($rose(host_bus_hold_o) |-> // R1
    ##63 host_bus_hold_o ##1 !host_bus_hold_o)
    else $error("host bus hold length wrong");
  mac_hold_set_a: assert property (wr_reset_ctl && reg_wdata_i[0] |=> mac_core_hold_o) // R2
    else $error("MAC hold not set");
  len_clear_a: assert property (wr_doze_ctl && reg_wdata_i[19] |=> !doze_busy) // R6
    else $error("doze counter not cleared");
  stat_gate_a: assert property (stat_irq_o |-> $past(doze_control[21])) // R8
    else $error("statistics interrupt while disabled");
  pend_mirror_a: assert property (reg_rd_i && sel_pend |=> // R9
    reg_rdata_o[0] == !$past(host_irq_n_o))
    else $error("pending bit differs from interrupt");
  force_read_a: assert property (reg_rd_i && sel_force |=> reg_rdata_o == 32'h0) // R10
    else $error("force register read not zero");
  force_doze_a: assert property (force_doze_seq |=> asleep_o) // R10
    else $error("force doze not taken");
  force_wake_a: assert property (force_wake_seq |=> !asleep_o) // R10
    else $error("force wake not taken");
  irq_quiet_a: assert property (asleep_o && !cfg[11] |=> host_irq_n_o) // R14
    else $error("interrupt asserted while dozing");
  pin_always_a: assert property (pincr[1:0] == 2'b11 |=> pin_oe_o[0]) // R20
    else $error("pin 0 not driven");
  pin_irq_a: assert property (pincr[15] && irq_src == 3'h0 && // R22
    pin_sync[0] == pincr[16] |=> pin_irq_o)
    else $error("pin interrupt missing");
endmodule

//--- tb/host_master.sv
// Host bus master model driving the register port
module host_master (
  input  wire logic        clk_sys_i,
  output logic      [15:0] addr_o,
  output logic             wr_o,
  output logic             rd_o,
  output logic      [31:0] wdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] exp_q[$];
  // Idle bus at time zero
  initial begin
    addr_o = 16'h0000;
    wr_o = 1'b0;
    rd_o = 1'b0;
    wdata_o = 32'h0;
  end
  // One-cycle write; released lines show the inverse
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(negedge clk_sys_i);
    addr_o = a;
    wdata_o = d;
    wr_o = 1'b1;
    @(negedge clk_sys_i);
    wr_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~d;
  endtask
  // One-cycle read, expected word noted
  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    @(negedge clk_sys_i);
    addr_o = a;
    rd_o = 1'b1;
    exp_q.push_back(e);
    @(negedge clk_sys_i);
    rd_o = 1'b0;
    addr_o = ~a;
  endtask
endmodule

//--- tb/host_domain_power_gpio_regs_tb.sv
// Self-checking bench for the host-domain power and pin register bank
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin n_fail++; \
  $display("Error %s expected %h seen %h", n, e, a); end end
module host_domain_power_gpio_regs_tb;
  import host_power_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0, rst_n = 1'b0, warm = 1'b0, beacon = 1'b0, irq = 1'b0;
  logic        slk = 1'b0, cld = 1'b0, csrc = 1'b0, cstop = 1'b0, rd_seen = 1'b0;
  logic [1:0]  rate = 2'h0;
  logic [5:0]  pdo = 6'h00, pin = 6'h00;
  logic [15:0] addr;
  logic        wr, rd;
  logic [31:0] wd, rdata, e, m;
  logic        mac, bb, hbh, asl, peer, hirq_n, stat, lsrc, cstp, befix, ind, idoff, pirq;
  doze_sel_t   sel;
  logic [1:0]  assoc;
  logic [5:0]  pout, poe;
  int          n_fail = 0, comparisons = 0, n;
  // Clocks: system 50 ns, low clock 400 ns
  always #25 clk = ~clk;
  always #200 slk = ~slk;
  host_master host_i (.clk_sys_i(clk), .addr_o(addr), .wr_o(wr), .rd_o(rd), .wdata_o(wd));
  host_domain_power_gpio_regs #(.PIN_COUNT(6), .LED_HOLD_CYC(20)) host_domain_power_gpio_regs_i (
    .clk_sys_i(clk), .rst_n_i(rst_n), .warm_rst_i(warm), .reg_addr_i(addr),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wd), .reg_rdata_o(rdata),
    .beacon_target_time_i(beacon), .irq_req_i(irq), .sleep_clk_i(slk), .cfg_load_i(cld),
    .cfg_clk_src_i(csrc), .cfg_clk_stop_i(cstop), .low_clock_rate_i(rate),
    .pin_out_value_i(pdo), .pin_in_i(pin), .mac_core_hold_o(mac), .baseband_hold_o(bb),
    .host_bus_hold_o(hbh), .asleep_o(asl), .doze_sel_o(sel),
    .peer_network_doze_policy_o(peer), .host_irq_n_o(hirq_n), .stat_irq_o(stat),
    .low_clock_source_o(lsrc), .clock_stop_permit_o(cstp), .assoc_state_o(assoc),
    .byte_enable_fix_en_o(befix), .indicator_doze_o(ind),
    .idle_indicator_off_o(idoff), .pin_o(pout), .pin_oe_o(poe), .pin_irq_o(pirq));
  // Read monitor: oldest note against the answer
  always @(posedge clk) rd_seen <= rd;
  always @(negedge clk) begin
    if (rd_seen) begin
      e = host_i.exp_q.pop_front();
      `CHK("rdata", e, rdata)
    end
  end
  task automatic tick(input int k);
    repeat (k) @(negedge clk);
  endtask
  // Expected drive enables from mode pairs
  function automatic logic [5:0] oe_of(input logic [11:0] md, input logic [5:0] d);
    logic [5:0] f;
    for (int i = 0; i < 6; i++) f[i] = (md[2*i+1] & d[i]) | (md[2*i] & ~d[i]);
    return f;
  endfunction
  task automatic summarize;
    $display("Checks %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Main sequence
  initial begin
    void'($urandom(55));
    rate = 2'($urandom);
    tick(12);
    rst_n = 1'b1;
    host_i.rd(16'h4000, 32'h3);
    host_i.rd(16'h4004, 32'h10000);
    host_i.rd(16'h4008, 32'h0);
    host_i.rd(16'h400C, 32'h0);
    host_i.rd(16'h4010, {6'h0, rate, 24'h010000});
    host_i.rd(16'h4014, 32'h0);
    host_i.rd(16'h4018, 32'h0);
    $display("Test reset values done");
    host_i.wr(16'h4004, 32'h0);
    tick(3);
    `CHK("asleep", 1'b0, asl)
    `CHK("doze_sel", SEL_WAKE, sel)
    host_i.rd(16'h4010, {6'h0, rate, 24'h0});
    host_i.wr(16'h4004, 32'h00120005);
    tick(3);
    `CHK("asleep", 1'b1, asl)
    `CHK("peer", 1'b1, peer)
    host_i.wr(16'h4004, 32'h001A0005);
    tick(3);
    `CHK("asleep", 1'b0, asl)
    beacon = 1'b1;
    tick(1);
    beacon = 1'b0;
    tick(3);
    `CHK("asleep", 1'b1, asl)
    $display("Test doze select done");
    host_i.wr(16'h4004, 32'h0);
    host_i.wr(16'h400C, 32'h1);
    tick(3);
    `CHK("asleep", 1'b1, asl)
    host_i.rd(16'h400C, 32'h0);
    host_i.wr(16'h400C, 32'h2);
    tick(3);
    `CHK("asleep", 1'b0, asl)
    `CHK("ind_hold", 1'b1, ind)
    irq = 1'b1;
    tick(3);
    `CHK("host_irq_n", 1'b0, hirq_n)
    host_i.rd(16'h4008, 32'h1);
    host_i.wr(16'h4004, 32'h10000);
    tick(3);
    `CHK("asleep", 1'b0, asl)
    host_i.wr(16'h4010, 32'h2000);
    tick(3);
    `CHK("asleep", 1'b1, asl)
    `CHK("host_irq_n", 1'b1, hirq_n)
    host_i.wr(16'h4010, 32'h2800);
    tick(3);
    `CHK("host_irq_n", 1'b0, hirq_n)
    irq = 1'b0;
    $display("Test force and interrupt done");
    host_i.wr(16'h4004, 32'h0);
    host_i.wr(16'h4010, 32'h00804C40);
    tick(2);
    `CHK("befix", 1'b0, befix)
    `CHK("idle_off", 1'b1, idoff)
    `CHK("assoc", 2'h2, assoc)
    host_i.rd(16'h4010, {6'h0, rate, 24'h804C40});
    csrc = 1'b1;
    cstop = 1'b1;
    cld = 1'b1;
    tick(1);
    cld = 1'b0;
    tick(1);
    `CHK("clk_src", 1'b1, lsrc)
    `CHK("clk_stop", 1'b1, cstp)
    host_i.wr(16'h4000, 32'h13);
    n = 0;
    for (int i = 0; i < 100 && hbh; i++) begin
      n++;
      tick(1);
    end
    `CHK("hold_len", 64, n)
    `CHK("bb_hold", 1'b1, bb)
    host_i.wr(16'h400C, 32'h1);
    tick(2);
    `CHK("ind_doze", 1'b1, ind)
    host_i.wr(16'h400C, 32'h2);
    tick(2);
    `CHK("ind_now", 1'b0, ind)
    $display("Test config and hold done");
    for (int k = 0; k < 8; k++) begin
      m = $urandom & 32'hFFF;
      pdo = 6'($urandom);
      host_i.wr(16'h4014, m);
      tick(2);
      `CHK("pin_oe", oe_of(m[11:0], pdo), poe)
      `CHK("pin_out", pdo, pout)
    end
    for (int s = 0; s < 6; s++) begin
      m = {15'h0, 1'($urandom), 1'b1, 3'(s), 12'h0};
      host_i.wr(16'h4014, m);
      repeat (2) begin
        pin = 6'($urandom);
        tick(7);
        `CHK("pin_irq", pin[s] == m[16], pirq)
      end
    end
    host_i.wr(16'h4014, 32'h155);
    host_i.wr(16'h4000, 32'h10);
    warm = 1'b1;
    tick(1);
    warm = 1'b0;
    host_i.rd(16'h4014, 32'h0);
    host_i.wr(16'h4000, 32'h0);
    tick(1);
    `CHK("mac_hold", 1'b0, mac)
    host_i.wr(16'h4014, 32'h155);
    warm = 1'b1;
    tick(1);
    warm = 1'b0;
    host_i.rd(16'h4014, 32'h155);
    tick(3);
    `CHK("stat_irq", 1'b0, stat)
    $display("Test pins and warm reset done");
    summarize();
  end
endmodule
